//--- common/dmx_pkg.sv
// constants and types for the data-move execution block
package dmx_pkg;
	localparam int PTR_W   = 16;
	localparam int DATA_W  = 8;
	localparam int OFS_W   = 6;
	localparam int BANK_W  = 5;
	localparam int PAGE_W  = 7;
	localparam int FADDR_W = 7;

	localparam logic [PTR_W-1:0]  PTR_RESET  = 16'h0000;
	localparam logic [PTR_W-1:0]  PTR_ONE    = 16'h0001;
	localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RESET = 5'h00;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;

	// instruction codes on the decode port
	typedef enum logic [2:0] {
		DMX_OP_NONE     = 3'b000,
		DMX_OP_LOAD_IND = 3'b001,
		DMX_OP_STORE_IND = 3'b010,
		DMX_OP_BANK_LIT = 3'b011,
		DMX_OP_PAGE_LIT = 3'b100,
		DMX_OP_ACC_LIT  = 3'b101,
		DMX_OP_ACC_FILE = 3'b110
	} dmx_op_t;

	typedef enum logic [1:0] {
		DMX_PM_PREINC  = 2'b00,
		DMX_PM_PREDEC  = 2'b01,
		DMX_PM_POSTINC = 2'b10,
		DMX_PM_POSTDEC = 2'b11
	} dmx_pmode_t;

	typedef enum logic [1:0] {
		DMX_ST_IDLE  = 2'b00,
		DMX_ST_WAIT  = 2'b01,
		DMX_ST_FETCH = 2'b10
	} dmx_state_t;

	typedef struct packed {
		dmx_state_t        state;
		logic [PTR_W-1:0]  ptr0;
		logic [PTR_W-1:0]  ptr1;
		logic [DATA_W-1:0] acc;
		logic              zero;
		logic              zero_we;
		logic [BANK_W-1:0] bank;
		logic [PAGE_W-1:0] page;
		logic [PTR_W-1:0]  mem_addr;
		logic [DATA_W-1:0] mem_wdata;
		logic              mem_rd;
		logic              mem_wr;
		logic [FADDR_W-1:0] file_addr;
		logic [DATA_W-1:0] file_wdata;
		logic              file_wr;
		logic              busy;
		logic              done;
	} dmx_regs_t;
endpackage : dmx_pkg

//--- src/dmx_exec.sv
// data-move instruction execution: indirect, literal and file moves
`timescale 1ns/10ps
// Function
// [RULE_01] indirect load puts the addressed data in acc and sets zero.
// [RULE_02] mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// [RULE_03] address is ptr+1, ptr-1, ptr+offset (-32..31), or ptr if post.
// [RULE_04] after the move the pointer steps +1 or -1, offset form keeps it.
// [RULE_05] the 16-bit pointer wraps modulo its range both ways.
// [RULE_06] the window has no storage; accesses use the pointer's address.
// [RULE_07] bank literal load puts a 5-bit literal in bank select, no flags.
// [RULE_08] page literal load puts 7 bits in the pc high latch, no flags.
// [RULE_09] literal load puts 8 bits in acc in one cycle, no flags.
// [RULE_10] acc-to-file writes acc to a 7-bit address, one cycle, no flags.
// [RULE_11] pointer steps by indirect moves never change a status flag.
// [RULE_12] indirect store writes acc with the load's modes and pointers.
// [RULE_13] a one-bit select picks which pointer and window is used.
module dmx_exec
	import dmx_pkg::*;
(
	input  wire logic               clk_in,        // core clock
	input  wire logic               reset_in,      // async reset, high
	input  wire logic               issue_in,      // instruction valid pulse
	input  wire logic [2:0]         op_in,         // instruction code
	input  wire logic [1:0]         pmode_in,      // pointer mode field
	input  wire logic               offset_sel_in, // use offset form
	input  wire logic [OFS_W-1:0]   offset_in,     // signed offset
	input  wire logic               ptr_sel_in,    // pointer select
	input  wire logic [DATA_W-1:0]  literal_in,    // literal operand
	input  wire logic [FADDR_W-1:0] faddr_in,      // file address
	input  wire logic [DATA_W-1:0]  mem_rdata_in,  // data one cycle after rd
	output logic [PTR_W-1:0]        mem_addr_out,  // data memory address
	output logic [DATA_W-1:0]       mem_wdata_out, // data memory write data
	output logic                    mem_rd_out,    // read strobe
	output logic                    mem_wr_out,    // write strobe
	output logic [FADDR_W-1:0]      file_addr_out, // file register address
	output logic [DATA_W-1:0]       file_wdata_out,// file register data
	output logic                    file_wr_out,   // file write strobe
	output logic [DATA_W-1:0]       acc_out,       // accumulator
	output logic                    zero_out,      // zero flag value
	output logic                    zero_we_out,   // zero flag update pulse
	output logic [BANK_W-1:0]       bank_out,      // bank select register
	output logic [PAGE_W-1:0]       page_out,      // pc high latch
	output logic [PTR_W-1:0]        ptr0_out,      // file pointer 0
	output logic [PTR_W-1:0]        ptr1_out,      // file pointer 1
	output logic                    busy_out,      // indirect load pending
	output logic                    done_out       // instruction finished
);
	dmx_regs_t r;
	dmx_regs_t next_r;

	function automatic logic [PTR_W-1:0] sext_ofs(
		input logic [OFS_W-1:0] o);
		sext_ofs = {{(PTR_W-OFS_W){o[OFS_W-1]}}, o};
	endfunction : sext_ofs

	logic [PTR_W-1:0] cur_ptr;
	logic [PTR_W-1:0] ptr_inc;
	logic [PTR_W-1:0] ptr_dec;
	logic [PTR_W-1:0] eff_addr;
	logic [PTR_W-1:0] new_ptr;
	logic             is_ind;

	always_comb begin
		cur_ptr = ptr_sel_in ? r.ptr1 : r.ptr0; // RULE_13
		// plain 16-bit adds wrap for free
		ptr_inc = cur_ptr + PTR_ONE; // RULE_05
		ptr_dec = cur_ptr - PTR_ONE; // RULE_05
		eff_addr = cur_ptr;
		new_ptr = cur_ptr;
		if (offset_sel_in) begin
			eff_addr = cur_ptr + sext_ofs(offset_in); // RULE_03
		end else begin
			case (dmx_pmode_t'(pmode_in)) // RULE_02
				DMX_PM_PREINC: begin
					eff_addr = ptr_inc; // RULE_03
					new_ptr = ptr_inc; // RULE_04
				end
				DMX_PM_PREDEC: begin
					eff_addr = ptr_dec; // RULE_03
					new_ptr = ptr_dec; // RULE_04
				end
				DMX_PM_POSTINC: new_ptr = ptr_inc; // RULE_04
				DMX_PM_POSTDEC: new_ptr = ptr_dec; // RULE_04
				default: new_ptr = cur_ptr;
			endcase
		end
	end

	assign is_ind = (op_in == DMX_OP_LOAD_IND) || (op_in == DMX_OP_STORE_IND);

	always_comb begin
		next_r = r;
		next_r.mem_rd = 1'b0;
		next_r.mem_wr = 1'b0;
		next_r.file_wr = 1'b0;
		next_r.zero_we = 1'b0;
		next_r.done = 1'b0;
		case (r.state)
			DMX_ST_IDLE: begin
				if (issue_in) begin
					if (is_ind) begin
						// window has no storage: go straight to memory
						next_r.mem_addr = eff_addr; // RULE_06
						// flags untouched by the pointer step
						if (ptr_sel_in) begin
							next_r.ptr1 = new_ptr; // RULE_11
						end else begin
							next_r.ptr0 = new_ptr; // RULE_11
						end
					end
					case (dmx_op_t'(op_in))
						DMX_OP_LOAD_IND: begin
							next_r.mem_rd = 1'b1; // RULE_01
							next_r.busy = 1'b1;
							next_r.state = DMX_ST_WAIT;
						end
						DMX_OP_STORE_IND: begin
							next_r.mem_wdata = r.acc; // RULE_12
							next_r.mem_wr = 1'b1; // RULE_12
							next_r.done = 1'b1;
						end
						DMX_OP_BANK_LIT: begin
							next_r.bank = literal_in[BANK_W-1:0]; // RULE_07
							next_r.done = 1'b1;
						end
						DMX_OP_PAGE_LIT: begin
							next_r.page = literal_in[PAGE_W-1:0]; // RULE_08
							next_r.done = 1'b1;
						end
						DMX_OP_ACC_LIT: begin
							next_r.acc = literal_in; // RULE_09
							next_r.done = 1'b1;
						end
						DMX_OP_ACC_FILE: begin
							next_r.file_addr = faddr_in; // RULE_10
							next_r.file_wdata = r.acc; // RULE_10
							next_r.file_wr = 1'b1; // RULE_10
							next_r.done = 1'b1;
						end
						default: next_r.done = 1'b0;
					endcase
				end
			end
			// memory answers the cycle after the read strobe
			DMX_ST_WAIT: next_r.state = DMX_ST_FETCH;
			DMX_ST_FETCH: begin
				next_r.acc = mem_rdata_in; // RULE_01
				next_r.zero = (mem_rdata_in == ACC_RESET); // RULE_01
				next_r.zero_we = 1'b1; // RULE_01
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.state = DMX_ST_IDLE;
			end
			default: next_r.state = DMX_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			r <= '0;
			r.state <= DMX_ST_IDLE;
			r.ptr0 <= PTR_RESET;
			r.ptr1 <= PTR_RESET;
			r.acc <= ACC_RESET;
			r.bank <= BANK_RESET;
			r.page <= PAGE_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign mem_addr_out = r.mem_addr;
	assign mem_wdata_out = r.mem_wdata;
	assign mem_rd_out = r.mem_rd;
	assign mem_wr_out = r.mem_wr;
	assign file_addr_out = r.file_addr;
	assign file_wdata_out = r.file_wdata;
	assign file_wr_out = r.file_wr;
	assign acc_out = r.acc;
	assign zero_out = r.zero;
	assign zero_we_out = r.zero_we;
	assign bank_out = r.bank;
	assign page_out = r.page;
	assign ptr0_out = r.ptr0;
	assign ptr1_out = r.ptr1;
	assign busy_out = r.busy;
	assign done_out = r.done;

	// taken issue; an issue while busy is dropped
	logic             take;
	logic             take_ind;
	logic [PTR_W-1:0] ptr_view [2];

	assign take = issue_in && !r.busy;
	assign take_ind = take && is_ind;
	// one view per pointer so one loop checks both
	assign ptr_view[0] = r.ptr0;
	assign ptr_view[1] = r.ptr1;

	sequence s_issue_load;
		issue_in && !busy_out && op_in == DMX_OP_LOAD_IND;
	endsequence

	// strobe, a cycle of memory latency, then the result
	sequence s_load_result;
		mem_rd_out && busy_out
		##1 busy_out && !mem_rd_out
		##1 zero_we_out && done_out && !busy_out;
	endsequence

	a_load_reads: assert property ( // RULE_01
		@(posedge clk_in) disable iff (reset_in)
		s_issue_load |=> mem_rd_out ##2 (zero_we_out && done_out
			&& acc_out == $past(mem_rdata_in)))
		else $error("indirect load did not land in accumulator");
	a_load_zero: assert property ( // RULE_01
		@(posedge clk_in) disable iff (reset_in)
		zero_we_out |-> zero_out == (acc_out == ACC_RESET))
		else $error("zero flag wrong after indirect load");
	a_preinc_addr: assert property ( // RULE_03
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && is_ind && !offset_sel_in
		 && pmode_in == DMX_PM_PREINC && !ptr_sel_in)
		|=> mem_addr_out == $past(ptr0_out) + PTR_ONE
			&& ptr0_out == mem_addr_out)
		else $error("pre-increment address or pointer wrong");
	a_postdec_ptr: assert property ( // RULE_04
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && is_ind && !offset_sel_in
		 && pmode_in == DMX_PM_POSTDEC && ptr_sel_in)
		|=> mem_addr_out == $past(ptr1_out)
			&& ptr1_out == $past(ptr1_out) - PTR_ONE)
		else $error("post-decrement pointer wrong");
	a_offset_keep: assert property ( // RULE_04
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && is_ind && offset_sel_in)
		|=> $stable(ptr0_out) && $stable(ptr1_out))
		else $error("offset form moved a pointer");
	a_bank_load: assert property ( // RULE_07
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && op_in == DMX_OP_BANK_LIT)
		|=> bank_out == $past(literal_in[BANK_W-1:0]) && !zero_we_out)
		else $error("bank literal not loaded");
	a_page_load: assert property ( // RULE_08
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && op_in == DMX_OP_PAGE_LIT)
		|=> page_out == $past(literal_in[PAGE_W-1:0]) && !zero_we_out)
		else $error("page literal not loaded");
	a_acc_lit: assert property ( // RULE_09
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && op_in == DMX_OP_ACC_LIT)
		|=> acc_out == $past(literal_in) && done_out && !zero_we_out)
		else $error("literal not loaded into accumulator");
	a_file_store: assert property ( // RULE_10
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && op_in == DMX_OP_ACC_FILE)
		|=> file_wr_out && file_wdata_out == $past(acc_out)
			&& file_addr_out == $past(faddr_in))
		else $error("accumulator not written to file");
	a_store_ind: assert property ( // RULE_12
		@(posedge clk_in) disable iff (reset_in)
		(issue_in && !busy_out && op_in == DMX_OP_STORE_IND)
		|=> mem_wr_out && mem_wdata_out == $past(acc_out) && !zero_we_out)
		else $error("indirect store wrong");

	a_load_steps: assert property ( // RULE_01
		@(posedge clk_in) disable iff (reset_in)
		s_issue_load |=> s_load_result)
		else $error("indirect load steps out of order");
	// refused issues must leave bank, page and both pointers alone and strobe no memory or file write
	a_busy_refuse: assert property ( // RULE_01
		@(posedge clk_in) disable iff (reset_in)
		busy_out |=> $stable(bank_out) && $stable(page_out)
			&& $stable(ptr0_out) && $stable(ptr1_out)
			&& !mem_wr_out && !file_wr_out)
		else $error("register changed while load busy");
	a_zero_hold: assert property ( // RULE_11
		@(posedge clk_in) disable iff (reset_in)
		!zero_we_out |-> $stable(zero_out))
		else $error("zero flag moved without an update");
	a_acc_hold: assert property ( // RULE_09
		@(posedge clk_in) disable iff (reset_in)
		(!busy_out && !(take && op_in == DMX_OP_ACC_LIT))
		|=> $stable(acc_out))
		else $error("accumulator moved without a load");
	a_bank_keep: assert property ( // RULE_07
		@(posedge clk_in) disable iff (reset_in)
		!(take && op_in == DMX_OP_BANK_LIT) |=> $stable(bank_out))
		else $error("bank select moved without its load");
	a_page_keep: assert property ( // RULE_08
		@(posedge clk_in) disable iff (reset_in)
		!(take && op_in == DMX_OP_PAGE_LIT) |=> $stable(page_out))
		else $error("pc high latch moved without its load");
	a_file_only: assert property ( // RULE_10
		@(posedge clk_in) disable iff (reset_in)
		!(take && op_in == DMX_OP_ACC_FILE) |=> !file_wr_out)
		else $error("file write without its instruction");
	a_mem_wr_only: assert property ( // RULE_12
		@(posedge clk_in) disable iff (reset_in)
		!(take && op_in == DMX_OP_STORE_IND) |=> !mem_wr_out)
		else $error("memory write without indirect store");
	a_ptr_idle: assert property ( // RULE_04
		@(posedge clk_in) disable iff (reset_in)
		!take_ind |=> $stable(ptr0_out) && $stable(ptr1_out))
		else $error("pointer moved without an indirect move");

	// same checks for both pointers; the unselected one must not move
	for (genvar g = 0; g < 2; g++) begin : g_ptr
		a_pre_dec: assert property ( // RULE_03
			@(posedge clk_in) disable iff (reset_in)
			(take_ind && !offset_sel_in && ptr_sel_in == 1'(g)
			 && pmode_in == DMX_PM_PREDEC)
			|=> mem_addr_out == $past(ptr_view[g]) - PTR_ONE
				&& ptr_view[g] == mem_addr_out)
			else $error("pre-decrement address or pointer wrong");
		a_post_inc: assert property ( // RULE_04
			@(posedge clk_in) disable iff (reset_in)
			(take_ind && !offset_sel_in && ptr_sel_in == 1'(g)
			 && pmode_in == DMX_PM_POSTINC)
			|=> mem_addr_out == $past(ptr_view[g])
				&& ptr_view[g] == $past(ptr_view[g]) + PTR_ONE)
			else $error("post-increment address or pointer wrong");
		a_post_dec: assert property ( // RULE_04
			@(posedge clk_in) disable iff (reset_in)
			(take_ind && !offset_sel_in && ptr_sel_in == 1'(g)
			 && pmode_in == DMX_PM_POSTDEC)
			|=> mem_addr_out == $past(ptr_view[g])
				&& ptr_view[g] == $past(ptr_view[g]) - PTR_ONE)
			else $error("post-decrement address or pointer wrong");
		a_offset_addr: assert property ( // RULE_03
			@(posedge clk_in) disable iff (reset_in)
			(take_ind && offset_sel_in && ptr_sel_in == 1'(g))
			|=> mem_addr_out == $past(ptr_view[g])
				+ PTR_W'($signed($past(offset_in))))
			else $error("offset address wrong");
		a_ptr_wrap: assert property ( // RULE_05
			@(posedge clk_in) disable iff (reset_in)
			(take_ind && !offset_sel_in && ptr_sel_in == 1'(g)
			 && ptr_view[g] == '1 && !pmode_in[0])
			|=> ptr_view[g] == '0)
			else $error("pointer did not wrap to zero");
		a_other_ptr: assert property ( // RULE_13
			@(posedge clk_in) disable iff (reset_in)
			(take_ind && ptr_sel_in != 1'(g)) |=> $stable(ptr_view[g]))
			else $error("unselected pointer moved");
	end : g_ptr
endmodule : dmx_exec

//--- verif/testbench.sv
// self-checking bench for the data-move execution block
`timescale 1ns/10ps
module testbench;
	import dmx_pkg::*;
	typedef struct packed {
		logic [2:0] op; logic [1:0] pm; logic os; logic [5:0] ofs; logic ps;
		logic [7:0] lit; logic [6:0] fa; logic [15:0] ea; logic [15:0] pn;
	} dmx_row_t;
	localparam dmx_row_t ROWS [13] = '{
		'{DMX_OP_ACC_LIT, 2'h0, 1'b0, 6'h00, 1'b0, 8'h5a, 7'h00, 16'h0, 16'h0},
		'{DMX_OP_BANK_LIT, 2'h0, 1'b0, 6'h00, 1'b0, 8'h0f, 7'h00, 16'h0, 16'h0},
		'{DMX_OP_PAGE_LIT, 2'h0, 1'b0, 6'h00, 1'b0, 8'h7f, 7'h00, 16'h0, 16'h0},
		'{DMX_OP_ACC_FILE, 2'h0, 1'b0, 6'h00, 1'b0, 8'h00, 7'h7f, 16'h0, 16'h0},
		'{DMX_OP_LOAD_IND, 2'h1, 1'b0, 6'h00, 1'b0, 8'h00, 7'h00, 16'hffff, 16'hffff},
		'{DMX_OP_ACC_LIT, 2'h0, 1'b0, 6'h00, 1'b0, 8'hff, 7'h00, 16'h0, 16'h0},
		'{DMX_OP_LOAD_IND, 2'h0, 1'b0, 6'h00, 1'b0, 8'h00, 7'h00, 16'h0000, 16'h0000},
		'{DMX_OP_STORE_IND, 2'h3, 1'b0, 6'h00, 1'b1, 8'h00, 7'h00, 16'h0000, 16'hffff},
		'{DMX_OP_STORE_IND, 2'h2, 1'b0, 6'h00, 1'b1, 8'h00, 7'h00, 16'hffff, 16'h0000},
		'{DMX_OP_LOAD_IND, 2'h3, 1'b1, 6'h20, 1'b1, 8'h00, 7'h00, 16'hffe0, 16'h0000},
		'{DMX_OP_STORE_IND, 2'h0, 1'b1, 6'h1f, 1'b0, 8'h00, 7'h00, 16'h001f, 16'h0000},
		'{DMX_OP_LOAD_IND, 2'h2, 1'b0, 6'h00, 1'b0, 8'h00, 7'h00, 16'h0000, 16'h0001},
		'{DMX_OP_ACC_FILE, 2'h0, 1'b0, 6'h00, 1'b0, 8'h00, 7'h00, 16'h0, 16'h0}};
	logic clk_in, reset_in, issue_in, offset_sel_in, ptr_sel_in;
	logic [2:0] op_in;
	logic [1:0] pmode_in;
	logic [5:0] offset_in;
	logic [7:0] literal_in, mem_wdata_out, file_wdata_out, acc_out;
	logic [7:0] mem_rdata_in = 8'h00;
	logic [6:0] faddr_in, file_addr_out, page_out;
	logic [15:0] mem_addr_out, ptr0_out, ptr1_out;
	logic [4:0] bank_out;
	logic mem_rd_out, mem_wr_out, file_wr_out, zero_out, zero_we_out;
	logic busy_out, done_out;
	logic [15:0] p [2];
	logic [7:0] acc;
	logic [4:0] bank;
	logic [6:0] page;
	logic zf;
	int err_total = 0;
	int check_count = 0;
	dmx_exec dmx_exec_i (.clk_in(clk_in), .reset_in(reset_in),
		.issue_in(issue_in), .op_in(op_in), .pmode_in(pmode_in),
		.offset_sel_in(offset_sel_in), .offset_in(offset_in),
		.ptr_sel_in(ptr_sel_in), .literal_in(literal_in), .faddr_in(faddr_in),
		.mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out),
		.mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out),
		.mem_wr_out(mem_wr_out), .file_addr_out(file_addr_out),
		.file_wdata_out(file_wdata_out), .file_wr_out(file_wr_out),
		.acc_out(acc_out), .zero_out(zero_out), .zero_we_out(zero_we_out),
		.bank_out(bank_out), .page_out(page_out), .ptr0_out(ptr0_out),
		.ptr1_out(ptr1_out), .busy_out(busy_out), .done_out(done_out));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// memory answers low address byte plus one; idle cycles toggle the bus
	always @(posedge clk_in) begin
		mem_rdata_in <= mem_rd_out ? mem_addr_out[7:0] + 8'h01 : ~mem_rdata_in;
	end
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task run(input dmx_row_t r);
		logic rd, wr, fw, zw, bz;
		logic [15:0] a;
		logic [7:0] wd;
		rd = 0; wr = 0; fw = 0; zw = 0; a = 16'h0; wd = 8'h0;
		bz = 0;
		@(posedge clk_in);
		issue_in <= 1'b1; op_in <= r.op; pmode_in <= r.pm;
		offset_sel_in <= r.os; offset_in <= r.ofs; ptr_sel_in <= r.ps;
		literal_in <= r.lit; faddr_in <= r.fa;
		@(posedge clk_in);
		issue_in <= 1'b0;
		for (int n = 0; n < 6; n++) begin
			@(negedge clk_in);
			if (mem_rd_out === 1'b1 || mem_wr_out === 1'b1) a = mem_addr_out;
			if (mem_wr_out === 1'b1) wd = mem_wdata_out;
			rd |= mem_rd_out === 1'b1; wr |= mem_wr_out === 1'b1;
			fw |= file_wr_out === 1'b1; zw |= zero_we_out === 1'b1;
			bz |= busy_out === 1'b1;
			if (done_out === 1'b1) break;
		end
		if (r.op == DMX_OP_LOAD_IND || r.op == DMX_OP_STORE_IND) begin
			p[r.ps] = r.pn;
			chk("mem_addr", a, r.ea);
		end
		if (r.op == DMX_OP_STORE_IND) chk("mem_wdata", wd, acc);
		if (r.op == DMX_OP_ACC_FILE) begin
			chk("file_addr", file_addr_out, r.fa);
			chk("file_wdata", file_wdata_out, acc);
		end
		case (r.op)
			DMX_OP_ACC_LIT:  acc = r.lit;
			DMX_OP_BANK_LIT: bank = r.lit[4:0];
			DMX_OP_PAGE_LIT: page = r.lit[6:0];
			DMX_OP_LOAD_IND: begin
				acc = r.ea[7:0] + 8'h01;
				zf = acc == 8'h00;
			end
			default: ;
		endcase
		chk("done", done_out, 1'b1);
		chk("busy", bz, r.op == DMX_OP_LOAD_IND);
		chk("rd", rd, r.op == DMX_OP_LOAD_IND);
		chk("wr", wr, r.op == DMX_OP_STORE_IND);
		chk("file_wr", fw, r.op == DMX_OP_ACC_FILE);
		chk("zero_we", zw, r.op == DMX_OP_LOAD_IND);
		chk("zero", zero_out, zf);
		chk("acc", acc_out, acc);
		chk("bank", bank_out, bank);
		chk("page", page_out, page);
		chk("ptr0", ptr0_out, p[0]);
		chk("ptr1", ptr1_out, p[1]);
	endtask : run
	task pulse(input logic [2:0] op1, input logic [2:0] op2, input logic [7:0] l);
		@(posedge clk_in);
		issue_in <= 1'b1; op_in <= op1; pmode_in <= 2'h0;
		offset_sel_in <= 1'b0; ptr_sel_in <= 1'b0;
		literal_in <= l;
		@(posedge clk_in);
		op_in <= op2; literal_in <= l;
		@(posedge clk_in);
		issue_in <= 1'b0;
		repeat (4) @(negedge clk_in);
	endtask : pulse
	initial begin
		#(100ns * 3000);
		err_total++;
		end_of_test();
	end
	initial begin
		reset_in = 1'b1; issue_in = 1'b0; op_in = 3'h0; pmode_in = 2'h0;
		offset_sel_in = 1'b0; offset_in = 6'h0; ptr_sel_in = 1'b0;
		literal_in = 8'h0; faddr_in = 7'h0;
		p[0] = 16'h0; p[1] = 16'h0; acc = 8'h0; bank = 5'h0; page = 7'h0;
		zf = 1'b0;
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		chk("rst acc", acc_out, ACC_RESET);
		chk("rst ptr", ptr0_out | ptr1_out, PTR_RESET);
		chk("rst busy", busy_out | done_out | zero_out, 1'b0);
		foreach (ROWS[i]) run(ROWS[i]);
		// second issue lands while the load is still busy and must be lost
		pulse(DMX_OP_LOAD_IND, DMX_OP_ACC_LIT, 8'hff);
		chk("busy acc", acc_out, 8'h03);
		chk("busy ptr0", ptr0_out, 16'h0002);
		pulse(DMX_OP_BANK_LIT, DMX_OP_PAGE_LIT, 8'h05);
		chk("b2b bank", bank_out, 5'h05);
		chk("b2b page", page_out, 7'h05);
		pulse(3'h7, 3'h7, 8'h11);
		chk("op7 acc", acc_out, 8'h03);
		chk("op7 bank", bank_out, 5'h05);
		@(posedge clk_in);
		reset_in <= 1'b1;
		@(negedge clk_in);
		chk("rst2 acc", acc_out, ACC_RESET);
		chk("rst2 bank", bank_out, BANK_RESET);
		chk("rst2 page", page_out, PAGE_RESET);
		chk("rst2 ptr0", ptr0_out, PTR_RESET);
		chk("rst2 ptr1", ptr1_out, PTR_RESET);
		chk("rst2 flags", busy_out | done_out | zero_out, 1'b0);
		@(posedge clk_in);
		reset_in <= 1'b0;
		// model follows the reset; first issue right after release
		acc = ACC_RESET;
		bank = BANK_RESET;
		page = PAGE_RESET;
		zf = 1'b0;
		p[0] = PTR_RESET;
		p[1] = PTR_RESET;
		run(ROWS[0]);
		end_of_test();
	end
endmodule : testbench
